// File: hdl/tcd_defines.vh
/*
 * register offsets, field positions, reset values and encodings of the
 * two channel transfer engine. assumes byte-wide register port.
 */
`ifndef TCD_DEFINES_VH
`define TCD_DEFINES_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define TCD_OFS_SRC_LOW     8'h20
`define TCD_OFS_SRC_MID     8'h21
`define TCD_OFS_SRC_TOP     8'h22
`define TCD_OFS_DST_LOW     8'h23
`define TCD_OFS_DST_MID     8'h24
`define TCD_OFS_DST_TOP     8'h25
`define TCD_OFS_C0_CNT_LOW  8'h26
`define TCD_OFS_C0_CNT_HIGH 8'h27
`define TCD_OFS_MEM_LOW     8'h28
`define TCD_OFS_MEM_MID     8'h29
`define TCD_OFS_MEM_TOP     8'h2a
`define TCD_OFS_C1_CNT_LOW  8'h2b
`define TCD_OFS_C1_CNT_HIGH 8'h2c
`define TCD_OFS_ROUTING     8'h2d
`define TCD_OFS_MODE        8'h2e
`define TCD_OFS_CONTROL     8'h2f
`define TCD_OFS_STATUS      8'h30

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TCD_RT_ALT_EN       7
`define TCD_RT_ALT_FF       6
`define TCD_MODE_BURST      1
`define TCD_CTL_DIR         1
`define TCD_CTL_EN0         2
`define TCD_CTL_EN1         3

// ----------------------------------------------------------------
// encodings and reset values
// ----------------------------------------------------------------
`define TCD_REQ_EXT0        2'b00
`define TCD_REQ_SER0        2'b01
`define TCD_REQ_SER1        2'b10
`define TCD_REQ_EXT1        2'b11
`define TCD_AM_INC          2'b00
`define TCD_AM_DEC          2'b01
`define TCD_AM_MFIX         2'b10
`define TCD_AM_IOFIX        2'b11
`define TCD_RST_BYTE        8'h00
`define TCD_RST_ADDR        20'h00000
`define TCD_RST_CNT         16'h0000

`endif

// File: hdl/tcd_dma_route.v
/*
 * two channel transfer engine: registers, request routing, alternation
 * flip-flop, address stepping and byte counting.
 * assumes a byte-wide register port on core_clk and request pins from
 * outside the clock domain; serial requests come from same-clock logic.
 *
 * register map, every register one byte:
 *   20h-22h  channel 0 source address
 *   23h-25h  channel 0 destination address
 *   26h-27h  channel 0 byte count
 *   28h-2ah  channel 1 memory address
 *   2bh-2ch  channel 1 byte count
 *   2dh      routing and alternation
 *   2eh      channel 0 address modes and burst
 *   2fh      direction and channel enables
 *   30h      status, read only
 *
 * limitations: channel 1 always counts its address up,
 * burst exists for channel 0 only, a zero count moves
 * nothing, and pin requests lag two cycles behind the pin.
 * the port never stalls and unmapped offsets read as zero.
 * both channel ends in one cycle leave the flip-flop alone.
 */
// Summary of operation
// R01 - channel 0 source top register bits 17:16 pick ext0, serial0 receive, serial1 receive or ext1.
// R02 - channel 0 destination top register bits 17:16 pick ext0, serial0 transmit, serial1 transmit or ext1.
// R03 - channel 0 source address is twenty bits over three byte registers at 20h to 22h.
// R04 - channel 0 byte count is sixteen bits at 26h low and 27h high.
// R05 - channel 1 memory address is twenty bits at 28h to 2ah, top nibble low in 2ah.
// R06 - channel 1 has its own sixteen bit byte count in low and high registers.
// R07 - software sets alternation only when both channels share one request source.
// R08 - with alternation on, channel 0 transfer end sets the flip-flop so only channel 1 sees the request.
// R09 - channel 1 transfer end clears the flip-flop so only channel 0 sees the request.
// R10 - with different sources, channel 0 request is forced onto channel 1 after the flip-flop sets.
// R11 - routing bit 6 is the flip-flop: 0 presents the request to channel 0, 1 to channel 1.
// R12 - with alternation on, a channel 0 end sets the select bit and a channel 1 end clears it.
// R13 - software writes zeros to routing bits 5 to 3.
// R14 - channel 1 request from routing bits 2:0 with direction: ext1, serial0, serial1, ext0.
// R15 - software avoids channel 1 select codes 100 to 111.
// R16 - address modes increment, decrement, fixed, io fixed; mode bit picks cycle steal or burst.
// R17 - each byte decrements the count and the last byte gives transfer end.
`include "tcd_defines.vh"

module tcd_dma_route
(
    // clock and reset
    input  wire        core_clk,
    input  wire        sys_rst,

    // register port
    input  wire [7:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata_ff,

    // request inputs
    input  wire        serial_clk0_or_ext_request_0,
    input  wire        ext_request_1_n,
    input  wire        ser0_rx_req,
    input  wire        ser0_tx_req,
    input  wire        ser1_rx_req,
    input  wire        ser1_tx_req,

    // transfer outputs
    output reg         ch0_xfer_ff,
    output reg         ch1_xfer_ff,
    output reg  [19:0] ch0_src_ff,
    output reg  [19:0] ch0_dst_ff,
    output reg  [19:0] ch1_mem_ff,
    output reg         transfer_end_ch0_ff,
    output reg         transfer_end_ch1_ff
);

    // ----------------------------------------------------------------
    // register storage
    // ----------------------------------------------------------------
    // top bytes keep bits 7:4 for read back
    reg  [7:0]  src_top_ff;
    reg  [7:0]  dst_top_ff;
    reg  [7:0]  mem_top_ff;

    // byte counters
    reg  [15:0] ch0_cnt_ff;
    reg  [15:0] ch1_cnt_ff;

    // control bytes
    reg  [7:0]  routing_ff;
    reg  [7:0]  mode_ff;
    reg  [7:0]  control_ff;

    // synchroniser stages
    reg  [1:0]  sync0_ff;
    reg  [1:0]  sync1_ff;

    // burst and status state
    reg         busy0_ff;
    reg         busy1_ff;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    // two stages: the first stage feeds only the second
    always @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sync0_ff <= 2'b00;
            sync1_ff <= 2'b00;
        end
        else
        begin
            sync0_ff <= {sync0_ff[0], serial_clk0_or_ext_request_0};
            sync1_ff <= {sync1_ff[0], ~ext_request_1_n};
        end
    end

    // only the second stage is read; pin 1 was inverted ahead of the first
    wire ext0_req = sync0_ff[1];
    wire ext1_req = sync1_ff[1];

    // ----------------------------------------------------------------
    // request routing
    // ----------------------------------------------------------------
    reg  src0_req;
    reg  dst0_req;
    reg  sel1_req;
    wire dir1 = control_ff[`TCD_CTL_DIR];

    // source side picks receive requests, destination side transmit
    always @*
    begin
        // channel 0 source side: receive requests
        case (src_top_ff[1:0])                                          // R01
            `TCD_REQ_EXT0: src0_req = ext0_req;
            `TCD_REQ_SER0: src0_req = ser0_rx_req;
            `TCD_REQ_SER1: src0_req = ser1_rx_req;
            default:       src0_req = ext1_req;
        endcase

        // channel 0 destination side: transmit requests
        case (dst_top_ff[1:0])                                          // R02
            `TCD_REQ_EXT0: dst0_req = ext0_req;
            `TCD_REQ_SER0: dst0_req = ser0_tx_req;
            `TCD_REQ_SER1: dst0_req = ser1_tx_req;
            default:       dst0_req = ext1_req;
        endcase

        // reserved codes 1xx route nothing, so a stray write cannot start cycles
        case (routing_ff[2:0])                                          // R14
            3'b000:  sel1_req = ext1_req;
            3'b001:  sel1_req = dir1 ? ser0_rx_req : ser0_tx_req;
            3'b010:  sel1_req = dir1 ? ser1_rx_req : ser1_tx_req;
            3'b011:  sel1_req = ext0_req;
            default: sel1_req = 1'b0;
        endcase
    end

    // channel 0 is a memory to io or io to memory mover: an io fixed source takes the destination side's request
    wire raw0_req = (mode_ff[3:2] == `TCD_AM_IOFIX) ? dst0_req : src0_req;
    // routing bit 7 enables alternation, bit 6 is the flip-flop
    wire alt_en   = routing_ff[`TCD_RT_ALT_EN];
    wire alt_ff   = routing_ff[`TCD_RT_ALT_FF];

    // channel 1's own select code is ignored while alternating
    // when alternating, the channel 0 request is the shared one and moves with the flip-flop
    wire req0 = alt_en ? (raw0_req & ~alt_ff) : raw0_req;              // R08 R11
    wire req1 = alt_en ? (alt_ff ? raw0_req : 1'b0) : sel1_req;        // R09 R10 R11

    // ----------------------------------------------------------------
    // transfer engine
    // ----------------------------------------------------------------
    // the count still holds one while its last byte moves
    wire last0 = (ch0_cnt_ff == 16'h0001);
    wire last1 = (ch1_cnt_ff == 16'h0001);

    wire burst0 = mode_ff[`TCD_MODE_BURST];
    // burst keeps going while enabled; cycle steal needs a request per byte
    wire go0 = control_ff[`TCD_CTL_EN0] & (ch0_cnt_ff != `TCD_RST_CNT)
               & (req0 | (burst0 & busy0_ff)) & ~ch0_xfer_ff;         // R16
    // channel 1 has no burst: every byte needs its own request
    wire go1 = control_ff[`TCD_CTL_EN1] & (ch1_cnt_ff != `TCD_RST_CNT)
               & req1 & ~ch1_xfer_ff;
    reg  [19:0] nxt_src;
    reg  [19:0] nxt_dst;

    // both fixed codes hold the address: io fixed on the source also selects the destination request
    always @*
    begin
        case (mode_ff[3:2])                                             // R16
            `TCD_AM_INC: nxt_src = ch0_src_ff + 20'h00001;
            `TCD_AM_DEC: nxt_src = ch0_src_ff - 20'h00001;
            default:     nxt_src = ch0_src_ff;
        endcase
        case (mode_ff[5:4])                                             // R16
            `TCD_AM_INC: nxt_dst = ch0_dst_ff + 20'h00001;
            `TCD_AM_DEC: nxt_dst = ch0_dst_ff - 20'h00001;
            default:     nxt_dst = ch0_dst_ff;
        endcase
    end

    // writes are never held off by a transfer
    wire wsel = reg_wr;

    // ----------------------------------------------------------------
    // registers and counters
    // ----------------------------------------------------------------
    // a byte moved in the same cycle as a software write: the write wins for data,
    // but the flip-flop set/clear from a channel end wins over a software write
    always @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ch0_src_ff          <= `TCD_RST_ADDR;
            ch0_dst_ff          <= `TCD_RST_ADDR;
            ch1_mem_ff          <= `TCD_RST_ADDR;
            src_top_ff          <= `TCD_RST_BYTE;
            dst_top_ff          <= `TCD_RST_BYTE;
            mem_top_ff          <= `TCD_RST_BYTE;
            ch0_cnt_ff          <= `TCD_RST_CNT;
            ch1_cnt_ff          <= `TCD_RST_CNT;

            routing_ff          <= `TCD_RST_BYTE;
            mode_ff             <= `TCD_RST_BYTE;
            control_ff          <= `TCD_RST_BYTE;

            ch0_xfer_ff         <= 1'b0;
            ch1_xfer_ff         <= 1'b0;
            busy0_ff            <= 1'b0;
            busy1_ff            <= 1'b0;
            transfer_end_ch0_ff <= 1'b0;
            transfer_end_ch1_ff <= 1'b0;
        end
        else
        begin
            // one pulse per byte, the end pulse rides on the last one
            ch0_xfer_ff         <= go0;
            ch1_xfer_ff         <= go1;
            transfer_end_ch0_ff <= go0 & last0;                         // R17
            transfer_end_ch1_ff <= go1 & last1;                         // R17
            busy0_ff            <= go0 ? ~last0 : busy0_ff & control_ff[`TCD_CTL_EN0];
            busy1_ff            <= go1 ? ~last1 : 1'b0;

            // a moved byte steps address and count
            if (go0)
            begin
                ch0_cnt_ff <= ch0_cnt_ff - 16'h0001;                    // R17
                ch0_src_ff <= nxt_src;                                  // R16
                ch0_dst_ff <= nxt_dst;                                  // R16
            end

            // channel 1 address always counts up
            if (go1)
            begin
                ch1_cnt_ff <= ch1_cnt_ff - 16'h0001;                    // R17
                ch1_mem_ff <= ch1_mem_ff + 20'h00001;
            end

            // software writes; source and destination top bytes also carry the routing codes
            if (wsel)
            begin
                case (reg_addr)
                    `TCD_OFS_SRC_LOW:     ch0_src_ff[7:0]   <= reg_wdata;          // R03
                    `TCD_OFS_SRC_MID:     ch0_src_ff[15:8]  <= reg_wdata;          // R03
                    `TCD_OFS_SRC_TOP:
                    begin
                        ch0_src_ff[19:16] <= reg_wdata[3:0];                       // R03
                        src_top_ff        <= reg_wdata;
                    end
                    `TCD_OFS_DST_LOW:     ch0_dst_ff[7:0]   <= reg_wdata;
                    `TCD_OFS_DST_MID:     ch0_dst_ff[15:8]  <= reg_wdata;
                    `TCD_OFS_DST_TOP:
                    begin
                        ch0_dst_ff[19:16] <= reg_wdata[3:0];
                        dst_top_ff        <= reg_wdata;
                    end
                    `TCD_OFS_C0_CNT_LOW:  ch0_cnt_ff[7:0]   <= reg_wdata;          // R04
                    `TCD_OFS_C0_CNT_HIGH: ch0_cnt_ff[15:8]  <= reg_wdata;          // R04
                    `TCD_OFS_MEM_LOW:     ch1_mem_ff[7:0]   <= reg_wdata;          // R05
                    `TCD_OFS_MEM_MID:     ch1_mem_ff[15:8]  <= reg_wdata;          // R05
                    `TCD_OFS_MEM_TOP:
                    begin
                        ch1_mem_ff[19:16] <= reg_wdata[3:0];                       // R05
                        mem_top_ff        <= reg_wdata;
                    end
                    `TCD_OFS_C1_CNT_LOW:  ch1_cnt_ff[7:0]   <= reg_wdata;          // R06
                    `TCD_OFS_C1_CNT_HIGH: ch1_cnt_ff[15:8]  <= reg_wdata;          // R06
                    `TCD_OFS_ROUTING:     routing_ff        <= reg_wdata;
                    `TCD_OFS_MODE:        mode_ff           <= reg_wdata;
                    `TCD_OFS_CONTROL:     control_ff        <= reg_wdata;
                    default:              ;
                endcase
            end

            // channel ends step the flip-flop, winning over a same-cycle write
            if (alt_en & (go0 & last0) & ~(go1 & last1))
                routing_ff[`TCD_RT_ALT_FF] <= 1'b1;                     // R08 R12
            else if (alt_en & (go1 & last1) & ~(go0 & last0))
                routing_ff[`TCD_RT_ALT_FF] <= 1'b0;                     // R09 R12
        end
    end

    // ----------------------------------------------------------------
    // read port
    // ----------------------------------------------------------------
    // unmapped offsets read as zero; data stands one cycle after the strobe
    always @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            reg_rdata_ff <= `TCD_RST_BYTE;
        else if (reg_rd)
        begin
            case (reg_addr)
                `TCD_OFS_SRC_LOW:     reg_rdata_ff <= ch0_src_ff[7:0];
                `TCD_OFS_SRC_MID:     reg_rdata_ff <= ch0_src_ff[15:8];
                `TCD_OFS_SRC_TOP:     reg_rdata_ff <= {src_top_ff[7:4], ch0_src_ff[19:16]};
                `TCD_OFS_DST_LOW:     reg_rdata_ff <= ch0_dst_ff[7:0];
                `TCD_OFS_DST_MID:     reg_rdata_ff <= ch0_dst_ff[15:8];
                `TCD_OFS_DST_TOP:     reg_rdata_ff <= {dst_top_ff[7:4], ch0_dst_ff[19:16]};
                `TCD_OFS_C0_CNT_LOW:  reg_rdata_ff <= ch0_cnt_ff[7:0];
                `TCD_OFS_C0_CNT_HIGH: reg_rdata_ff <= ch0_cnt_ff[15:8];
                `TCD_OFS_MEM_LOW:     reg_rdata_ff <= ch1_mem_ff[7:0];
                `TCD_OFS_MEM_MID:     reg_rdata_ff <= ch1_mem_ff[15:8];
                `TCD_OFS_MEM_TOP:     reg_rdata_ff <= {mem_top_ff[7:4], ch1_mem_ff[19:16]};
                `TCD_OFS_C1_CNT_LOW:  reg_rdata_ff <= ch1_cnt_ff[7:0];
                `TCD_OFS_C1_CNT_HIGH: reg_rdata_ff <= ch1_cnt_ff[15:8];
                `TCD_OFS_ROUTING:     reg_rdata_ff <= routing_ff;
                `TCD_OFS_MODE:        reg_rdata_ff <= mode_ff;
                `TCD_OFS_CONTROL:     reg_rdata_ff <= control_ff;
                // status shows the routed requests and the busy state
                `TCD_OFS_STATUS:      reg_rdata_ff <= {4'h0, busy1_ff, busy0_ff, req1, req0};
                default:              reg_rdata_ff <= `TCD_RST_BYTE;
            endcase
        end
        // no strobe: the data lines return to zero
        else
            reg_rdata_ff <= `TCD_RST_BYTE;
    end

endmodule // tcd_dma_route

// File: test/tcd_dma_route_chk.sv
/*
 * port checker for the two channel transfer engine.
 * assumes one clock, async high reset and the mode register at 2eh.
 */
module tcd_dma_route_chk
(
    input wire logic        core_clk,
    input wire logic        sys_rst,
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata_ff,
    input wire logic        ch0_xfer_ff,
    input wire logic        ch1_xfer_ff,
    input wire logic [19:0] ch0_src_ff,
    input wire logic [19:0] ch0_dst_ff,
    input wire logic [19:0] ch1_mem_ff,
    input wire logic        transfer_end_ch0_ff,
    input wire logic        transfer_end_ch1_ff
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] mode_ff;

    // shadow of the mode register, the stepping direction is not visible at the ports
    always @(posedge core_clk or posedge sys_rst)
        if (sys_rst)
            mode_ff <= 8'h00;
        else if (reg_wr && reg_addr == 8'h2e)
            mode_ff <= reg_wdata;

    function automatic logic [19:0] step(input logic [1:0] m);
        return (m == 2'b00) ? 20'h00001 : (m == 2'b01) ? 20'hfffff : 20'h00000;
    endfunction

    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    property p_rd_idle; !$past(reg_rd) |-> reg_rdata_ff == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside its slot");
    property p_end0; transfer_end_ch0_ff |-> ch0_xfer_ff; endproperty
    a_end0: assert property (p_end0) else $error("ch0 end without byte");
    property p_end1; transfer_end_ch1_ff |-> ch1_xfer_ff; endproperty
    a_end1: assert property (p_end1) else $error("ch1 end without byte");
    property p_gap0; ch0_xfer_ff |=> !ch0_xfer_ff; endproperty
    a_gap0: assert property (p_gap0) else $error("ch0 bytes too close");
    property p_gap1; ch1_xfer_ff |=> !ch1_xfer_ff; endproperty
    a_gap1: assert property (p_gap1) else $error("ch1 bytes too close");
    property p_src_step; ch0_xfer_ff |-> ch0_src_ff == $past(ch0_src_ff) + step(mode_ff[3:2]); endproperty
    a_src_step: assert property (p_src_step) else $error("ch0 source step wrong");
    property p_dst_step; ch0_xfer_ff |-> ch0_dst_ff == $past(ch0_dst_ff) + step(mode_ff[5:4]); endproperty
    a_dst_step: assert property (p_dst_step) else $error("ch0 destination step wrong");
    property p_mem_inc; ch1_xfer_ff |-> ch1_mem_ff == $past(ch1_mem_ff) + 20'h00001; endproperty
    a_mem_inc: assert property (p_mem_inc) else $error("ch1 address not stepped");
    property p_mem_hold; !ch1_xfer_ff && !$past(reg_wr) |-> $stable(ch1_mem_ff); endproperty
    a_mem_hold: assert property (p_mem_hold) else $error("ch1 address moved");
endmodule // tcd_dma_route_chk

bind tcd_dma_route tcd_dma_route_chk u_chk
(
    .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .ch0_xfer_ff(ch0_xfer_ff),
    .ch1_xfer_ff(ch1_xfer_ff), .ch0_src_ff(ch0_src_ff), .ch0_dst_ff(ch0_dst_ff), .ch1_mem_ff(ch1_mem_ff),
    .transfer_end_ch0_ff(transfer_end_ch0_ff), .transfer_end_ch1_ff(transfer_end_ch1_ff)
);

// File: test/tcd_dma_route_test.sv
/*
 * self checking bench for the two channel transfer engine.
 * assumes the request model and the bound port checker.
 */
module tcd_dma_route_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk, sys_rst, reg_wr, reg_rd, e0, e1_n, s0r, s0t, s1r, s1t;
    logic ch0_xfer_ff, ch1_xfer_ff, transfer_end_ch0_ff, transfer_end_ch1_ff;
    logic [7:0] reg_addr, reg_wdata, reg_rdata_ff;
    logic [19:0] ch0_src_ff, ch0_dst_ff, ch1_mem_ff;
    logic [5:0] req_mask;
    int bad_count = 0;
    int compares = 0;
    int stab[4] = '{4, 0, 2, 5};
    int dtab[4] = '{4, 1, 3, 5};
    int ctab[8] = '{5, 1, 3, 4, 5, 0, 2, 4};

    tcd_dma_route dut (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .serial_clk0_or_ext_request_0(e0),
        .ext_request_1_n(e1_n), .ser0_rx_req(s0r), .ser0_tx_req(s0t), .ser1_rx_req(s1r), .ser1_tx_req(s1t),
        .ch0_xfer_ff(ch0_xfer_ff), .ch1_xfer_ff(ch1_xfer_ff), .ch0_src_ff(ch0_src_ff), .ch0_dst_ff(ch0_dst_ff),
        .ch1_mem_ff(ch1_mem_ff), .transfer_end_ch0_ff(transfer_end_ch0_ff),
        .transfer_end_ch1_ff(transfer_end_ch1_ff));
    tcd_far_model u_far (.req_mask(req_mask), .ser0_rx_req(s0r), .ser0_tx_req(s0t), .ser1_rx_req(s1r),
        .ser1_tx_req(s1t), .ext_req_0(e0), .ext_req_1_n(e1_n));

    initial
    begin
        core_clk = 0;
        forever #20 core_clk = ~core_clk;
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task end_of_test;
        if (bad_count == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task chk(input logic [19:0] got, input logic [19:0] exp);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge core_clk) reg_wr <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk) {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge core_clk) reg_rd <= 1'b0;
        #1 chk(reg_rdata_ff, exp);
    endtask

    // counts byte pulses until the channel ends; ch 2 means a quiet window
    task automatic go(input int ch, input int n);
        int c0, c1, k;
        bit hit;
        c0 = 0;
        c1 = 0;
        hit = 0;
        for (k = 0; k < (ch == 2 ? 12 : 40) && !hit; k++)
        begin
            #1;
            c0 += (ch0_xfer_ff === 1'b1);
            c1 += (ch1_xfer_ff === 1'b1);
            hit = (ch == 0) ? (transfer_end_ch0_ff === 1'b1) : (ch == 1) && (transfer_end_ch1_ff === 1'b1);
            if (!hit)
                @(posedge core_clk);
        end
        if (ch < 2 && !hit)
        begin
            bad_count++;
            $display("ERROR %0t transfer end never seen", $time);
            end_of_test;
        end
        else
        begin
            chk(c0, ch == 0 ? n : 0);
            chk(c1, ch == 1 ? n : 0);
        end
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic s_regs;
        logic [7:0] a;
        for (a = 8'h20; a <= 8'h2c; a++)
        begin
            rd(a, 8'h00);
            wr(a, a ^ 8'h5a);
            rd(a, a ^ 8'h5a);
        end
        wr(8'h40, 8'hff);
        rd(8'h40, 8'h00);
    endtask

    // every ch0 select code and address mode, source side then destination side
    task automatic s_ch0;
        logic [19:0] base, stp;
        logic [1:0] i;
        int k, d, b;
        for (k = 0; k < 8; k++)
        begin
            i = 2'(k % 4);
            d = k / 4;
            base = {2'b00, i, 16'h2345};
            stp = (i == 2'b00) ? 20'h00002 : (i == 2'b01) ? 20'hffffe : 20'h00000;
            b = d ? dtab[i] : stab[i];
            wr(8'h20, 8'h45);
            wr(8'h21, 8'h23);
            wr(8'h22, {6'h00, i});
            wr(8'h23, 8'h45);
            wr(8'h24, 8'h23);
            wr(8'h25, {6'h00, i});
            wr(8'h2e, d ? {2'b00, i, 4'b1100} : {4'b0000, i, 2'b00});
            wr(8'h26, 8'h02);
            wr(8'h27, 8'h00);
            wr(8'h2f, 8'h04);
            @(posedge core_clk) req_mask <= ~(6'h01 << b);
            go(2, 0);
            @(posedge core_clk) req_mask <= 6'h01 << b;
            go(0, 2);
            @(posedge core_clk) req_mask <= 6'h00;
            chk(ch0_src_ff, d ? base : base + stp);
            chk(ch0_dst_ff, d ? base + stp : base + 20'h00002);
            rd(8'h26, 8'h00);
        end
    endtask

    // every ch1 code in both directions, then a reserved code
    task automatic s_ch1;
        int k;
        for (k = 0; k < 9; k++)
        begin
            wr(8'h28, 8'h00);
            wr(8'h29, 8'h10);
            wr(8'h2a, 8'h00);
            wr(8'h2b, 8'h01);
            wr(8'h2c, 8'h00);
            wr(8'h2d, (k == 8) ? 8'h04 : 8'(k % 4));
            wr(8'h2f, (k / 4 == 1) ? 8'h0a : 8'h08);
            @(posedge core_clk) req_mask <= (k == 8) ? 6'h3f : 6'h01 << ctab[k % 8];
            go(k == 8 ? 2 : 1, k == 8 ? 0 : 1);
            @(posedge core_clk) req_mask <= 6'h00;
            chk(ch1_mem_ff, (k == 8) ? 20'h01000 : 20'h01001);
        end
    endtask

    // a one cycle request keeps burst going to the end
    task s_burst;
        wr(8'h22, 8'h01);
        wr(8'h2e, 8'h02);
        wr(8'h26, 8'h03);
        wr(8'h27, 8'h00);
        wr(8'h2f, 8'h04);
        @(posedge core_clk) req_mask <= 6'h01;
        @(posedge core_clk) req_mask <= 6'h00;
        go(0, 3);
    endtask

    // alternation with a shared source, then with a different ch1 source
    task automatic s_alt;
        logic [7:0] j;
        for (j = 8'h01; j <= 8'h02; j++)
        begin
            wr(8'h22, 8'h01);
            wr(8'h2e, 8'h00);
            wr(8'h26, 8'h01);
            wr(8'h27, 8'h00);
            wr(8'h2b, 8'h00);
            wr(8'h2c, 8'h00);
            wr(8'h2d, 8'h80 | j);
            wr(8'h2f, 8'h0e);
            @(posedge core_clk) req_mask <= 6'h01;
            go(0, 1);
            rd(8'h2d, 8'hc0 | j);
            rd(8'h30, 8'h02);
            wr(8'h2b, 8'h01);
            go(1, 1);
            rd(8'h2d, 8'h80 | j);
            @(posedge core_clk) req_mask <= 6'h00;
        end
    endtask

    initial
    begin
        sys_rst = 1'b1;
        {reg_wr, reg_rd, reg_addr, reg_wdata, req_mask} = '0;
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        s_regs;
        s_ch0;
        s_ch1;
        s_burst;
        s_alt;
        end_of_test;
    end
endmodule // tcd_dma_route_test

// File: test/tcd_far_model.sv
/*
 * request sources beside the engine: two serial channels and two pins.
 * assumes the bench raises and drops each request as a level.
 */
module tcd_far_model
(
    input  wire logic [5:0] req_mask,
    output wire logic       ser0_rx_req,
    output wire logic       ser0_tx_req,
    output wire logic       ser1_rx_req,
    output wire logic       ser1_tx_req,
    output wire logic       ext_req_0,
    output wire logic       ext_req_1_n
);
    timeunit 1ns;
    timeprecision 100ps;
    // serial requests are same clock levels, pin 1 is active low
    assign ser0_rx_req = req_mask[0];
    assign ser0_tx_req = req_mask[1];
    assign ser1_rx_req = req_mask[2];
    assign ser1_tx_req = req_mask[3];
    assign ext_req_0   = req_mask[4];
    assign ext_req_1_n = ~req_mask[5];
endmodule // tcd_far_model
